/* File: rtl/flash_block_protect_decode.sv */
// flash_block_protect_decode: checks each program or erase command against
// the status-register range protection or the external block lock, and
// either starts the array operation or finishes the command refused.
// assumes the command source holds cmd_* until cmd_ready, the array engine
// pulses array_done once per array_start, lock_hit answers lock_query_addr
// one cycle after the command is taken.
//
// Behaviour
// - each 4 kB block holds sixteen 256-byte pages; page erase uses address bits above 7.
// - page program takes 1 to 256 bytes, kept within the addressed page.
// - range protection applies only while the scheme select bit is zero.
// - complement bit set inverts protected and unprotected areas.
// - granularity bit picks 64 kB units (0) or 4 kB units (1).
// - origin bit picks range growing from top (0) or from zero (1).
// - extent field sizes the protected area; program and erase there are blocked.
// - 64 kB top: codes 1-4 protect top 64k/128k/256k/512k, 5-7 everything.
// - 64 kB bottom: codes 1-4 protect from zero 64k..512k, 5-7 everything.
// - 4 kB top: codes 1-3 protect top 4k/8k/16k, 4-5 top 32k, 6-7 everything.
// - 4 kB bottom: codes 1-3 protect low 4k/8k/16k, 4-5 low 32k, 6-7 everything.
// - code zero without complement protects nothing; outside addresses stay writable.
// - complement 64 kB top: protect below the top range; codes 5-7 nothing.
// - complement 64 kB bottom: code 0 all, 1-4 above low range, 5-7 nothing.
// - complement 4 kB top: protect below the top range; codes 6-7 nothing.
// - complement 4 kB bottom: code 0 all, 1-5 above low range, 6-7 nothing.
// - complement 4 kB top: 32k/64k erases see the unprotected range widened to their alignment.
// - complement 4 kB bottom: 32k/64k erases see the unprotected range widened to their alignment.
// - scheme select set ignores range fields and uses the block lock answer.
`timescale 1ns/100ps
`include "flash_protect_params.svh"
module flash_block_protect_decode #(
    parameter int ARRAY_AW = `ARRAY_AW,                                 // array address bits
    parameter int CMD_AW   = `CMD_AW                                    // command address bits
) (
    input  wire logic                          sys_clk,                 // 100 MHz clock
    input  wire logic                          rst_n,                   // async reset, low
    input  wire logic                          scheme_select_bit,       // 1: block lock scheme
    input  wire logic                          complement_protect_bit,  // invert protection
    input  wire logic                          protect_granularity_bit, // 1: 4 kB units
    input  wire logic                          range_origin_bit,        // 1: from address zero
    input  wire logic [2:0]                    protect_extent_field,    // extent code
    input  wire logic                          cmd_valid,               // command request
    input  wire flash_protect_pkg::flash_op_e  cmd_op,                  // command kind
    input  wire logic [CMD_AW-1:0]             cmd_addr,                // target byte address
    input  wire logic [`LEN_W-1:0]             cmd_len,                 // program byte count
    input  wire logic                          lock_hit,                // block lock answer
    input  wire logic                          array_done,              // array cycle ended
    output logic                               cmd_ready,               // command taken
    output logic [ARRAY_AW-1:0]                lock_query_addr,         // address for lock lookup
    output logic                               array_start,             // start array cycle
    output flash_protect_pkg::flash_op_e       array_op,                // operation started
    output logic [ARRAY_AW-1:0]                array_lo_addr,           // first byte of span
    output logic [ARRAY_AW-1:0]                array_hi_addr,           // last byte of span
    output logic                               cmd_done,                // command finished
    output logic                               cmd_refused              // finished refused
);
    import flash_protect_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (ARRAY_AW != `ARRAY_AW)
    begin : g_bad_array_aw
        $error("array address width must be 20");
    end
    if (CMD_AW < ARRAY_AW)
    begin : g_bad_cmd_aw
        $error("command address narrower than array address");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command span

    prot_state_e               state_reg;
    logic                      accept;
    logic [ARRAY_AW-1:0]       addr_a;
    logic [ARRAY_AW-1:0]       span_mask;
    logic [ARRAY_AW-1:0]       span_lo;
    logic [ARRAY_AW-1:0]       span_hi;
    logic [9:0]                page_sum;
    logic [7:0]                last_byte;
    logic                      len_bad;

    assign accept    = cmd_valid && cmd_ready;
    assign addr_a    = cmd_addr[ARRAY_AW-1:0];
    assign span_mask = op_span_mask(cmd_op);
    assign page_sum  = {2'b00, addr_a[7:0]} + {1'b0, cmd_len};
    assign last_byte = 8'(page_sum - 10'h001);

    always_comb
    begin
        span_lo = addr_a & ~span_mask;
        span_hi = addr_a | span_mask;
        if (cmd_op == OP_PAGE_PROGRAM && page_sum <= `PAGE_SUM_MAX)
        begin
            span_lo = addr_a;
            span_hi = {addr_a[ARRAY_AW-1:8], last_byte};
        end
    end

    assign len_bad = (cmd_op == OP_PAGE_PROGRAM) &&
                     (cmd_len < `PROG_LEN_MIN || cmd_len > `PROG_LEN_MAX);

    ////////////////////////////////////////////////////////////////////////////////
    // snapshot of command and protection fields

    logic                      snap_scheme_reg;
    logic                      snap_cmp_reg;
    logic                      snap_gran_reg;
    logic                      snap_origin_reg;
    logic [2:0]                snap_extent_reg;
    flash_op_e                 snap_op_reg;
    logic [ARRAY_AW-1:0]       snap_lo_reg;
    logic [ARRAY_AW-1:0]       snap_hi_reg;
    logic                      snap_bad_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            snap_scheme_reg <= 1'b0;
            snap_cmp_reg    <= 1'b0;
            snap_gran_reg   <= 1'b0;
            snap_origin_reg <= 1'b0;
            snap_extent_reg <= 3'h0;
            snap_op_reg     <= OP_PAGE_PROGRAM;
            snap_lo_reg     <= '0;
            snap_hi_reg     <= '0;
            snap_bad_reg    <= 1'b0;
            lock_query_addr <= '0;
        end
        else if (accept)
        begin
            snap_scheme_reg <= scheme_select_bit;
            snap_cmp_reg    <= complement_protect_bit;
            snap_gran_reg   <= protect_granularity_bit;
            snap_origin_reg <= range_origin_bit;
            snap_extent_reg <= protect_extent_field;
            snap_op_reg     <= cmd_op;
            snap_lo_reg     <= span_lo;
            snap_hi_reg     <= span_hi;
            snap_bad_reg    <= len_bad || (cmd_op > OP_CHIP_ERASE);
            lock_query_addr <= addr_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // range decode

    logic                      range_hit;
    logic                      refuse;

    flash_prot_range_check u_range_check (
        .complement_protect_bit  (snap_cmp_reg),
        .protect_granularity_bit (snap_gran_reg),
        .range_origin_bit        (snap_origin_reg),
        .protect_extent_field    (snap_extent_reg),
        .op                      (snap_op_reg),
        .op_lo                   (snap_lo_reg),
        .op_hi                   (snap_hi_reg),
        .hit                     (range_hit)
    );

    assign refuse = snap_bad_reg || (snap_scheme_reg ? lock_hit : range_hit);

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE  : if (accept) state_reg <= ST_CHECK;
                ST_CHECK : state_reg <= refuse ? ST_IDLE : ST_BUSY;
                ST_BUSY  : if (array_done) state_reg <= ST_IDLE;
                default  : state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd_ready <= 1'b0;
        else
            cmd_ready <= (state_reg == ST_IDLE) && !accept;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            array_start   <= 1'b0;
            array_op      <= OP_PAGE_PROGRAM;
            array_lo_addr <= '0;
            array_hi_addr <= '0;
        end
        else
        begin
            array_start <= (state_reg == ST_CHECK) && !refuse;
            if (state_reg == ST_CHECK && !refuse)
            begin
                array_op      <= snap_op_reg;
                array_lo_addr <= snap_lo_reg;
                array_hi_addr <= snap_hi_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_done    <= 1'b0;
            cmd_refused <= 1'b0;
        end
        else
        begin
            cmd_done    <= (state_reg == ST_CHECK && refuse) ||
                           (state_reg == ST_BUSY && array_done);
            cmd_refused <= (state_reg == ST_CHECK) && refuse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    logic chk_range;
    assign chk_range = (state_reg == ST_CHECK) && !snap_scheme_reg && !snap_bad_reg;

    AST_REFUSE_NO_START: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cmd_refused |-> (!array_start ##1 !array_start))
        else $error("array cycle started for a refused command");

    AST_ACCEPT_DECIDES: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        accept |-> ##2 (array_start != cmd_refused))
        else $error("command not decided two cycles after it was taken");

    AST_LOCK_SCHEME: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_CHECK && snap_scheme_reg && !snap_bad_reg) |=> (cmd_refused == $past(lock_hit)))
        else $error("lock scheme answer not followed");

    AST_PROG_LEN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (accept && cmd_op == OP_PAGE_PROGRAM && (cmd_len == 9'h000 || cmd_len > 9'h100))
        |-> ##2 cmd_refused)
        else $error("bad program length not refused");

    AST_PAGE_SPAN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (array_start && array_op == OP_PAGE_ERASE) |->
        (array_lo_addr[7:0] == 8'h00 && array_hi_addr == (array_lo_addr | 20'h0_00FF)))
        else $error("page erase span not one aligned page");

    AST_PROG_IN_PAGE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (array_start && array_op == OP_PAGE_PROGRAM) |->
        (array_lo_addr[19:8] == array_hi_addr[19:8] && array_lo_addr <= array_hi_addr))
        else $error("program span leaves its page");

    AST_ZERO_EXTENT: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && !snap_cmp_reg && snap_extent_reg == 3'h0) |=> array_start)
        else $error("code zero refused a command");

    AST_FULL_64K: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && !snap_cmp_reg && !snap_gran_reg && snap_extent_reg >= 3'h5) |=> cmd_refused)
        else $error("whole-array code did not protect");

    AST_CMP_NONE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && snap_cmp_reg && snap_gran_reg && snap_extent_reg >= 3'h6) |=> !cmd_refused)
        else $error("complement none code refused a command");

    AST_CMP_ALL: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && snap_cmp_reg && snap_extent_reg == 3'h0) |=> cmd_refused)
        else $error("complement code zero did not protect");

    AST_SNAPSHOT: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        accept |=> (snap_extent_reg == $past(protect_extent_field) &&
                    snap_cmp_reg == $past(complement_protect_bit)))
        else $error("protection fields not captured at decode");

    AST_TOP_64K: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && !snap_cmp_reg && !snap_gran_reg && !snap_origin_reg &&
         snap_extent_reg == 3'h1 && snap_hi_reg < 20'hF_0000) |=> array_start)
        else $error("address below top 64 kB refused");

    AST_CMP_32K_WIDEN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && snap_cmp_reg && snap_gran_reg && !snap_origin_reg &&
         snap_extent_reg == 3'h1 && snap_op_reg == OP_ERASE_32K && snap_lo_reg == 20'hF_8000)
        |=> array_start)
        else $error("top 32 kB erase refused in complement mode");

    AST_BOTTOM_64K: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && !snap_cmp_reg && !snap_gran_reg && snap_origin_reg &&
         snap_extent_reg == 3'h1 && snap_lo_reg >= 20'h1_0000) |=> array_start)
        else $error("address above low 64 kB refused");

    AST_TOP_4K: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && !snap_cmp_reg && snap_gran_reg && !snap_origin_reg &&
         snap_extent_reg == 3'h1 && snap_hi_reg < 20'hF_F000) |=> array_start)
        else $error("address below top 4 kB refused");

    AST_LOW_4K_ALL: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && !snap_cmp_reg && snap_gran_reg && snap_origin_reg && snap_extent_reg == 3'h6)
        |=> cmd_refused)
        else $error("whole-array low code did not protect");

    AST_CMP_TOP_64K: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && snap_cmp_reg && !snap_gran_reg && !snap_origin_reg &&
         snap_extent_reg == 3'h1 && snap_lo_reg >= 20'hF_0000) |=> array_start)
        else $error("top 64 kB refused in complement mode");

    AST_CMP_64K_WIDEN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (chk_range && snap_cmp_reg && snap_gran_reg && snap_origin_reg && snap_extent_reg == 3'h1 &&
         snap_op_reg == OP_ERASE_64K && snap_lo_reg == 20'h0_0000) |=> array_start)
        else $error("bottom 64 kB erase refused in complement mode");

    AST_BUSY_DONE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (state_reg == ST_BUSY && array_done) |=> (cmd_done && !cmd_refused) ##1 cmd_ready)
        else $error("array completion not reported");

endmodule : flash_block_protect_decode

/* File: common/flash_protect_params.svh */
// flash_protect_params.svh: address-space geometry, page and block spans and
// protect-extent thresholds for the block protection decoder.
// assumes a 1 MB (20-bit) byte-addressed array and 24-bit command addresses.
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH

// geometry
`define ARRAY_AW          20
`define CMD_AW            24
`define LEN_W             9
`define ARRAY_BYTES       21'h10_0000
`define ARRAY_LAST        20'hF_FFFF

// alignment masks of each operation span
`define MASK_PAGE         20'h0_00FF
`define MASK_4K           20'h0_0FFF
`define MASK_32K          20'h0_7FFF
`define MASK_64K          20'h0_FFFF

// protect unit sizes
`define UNIT_64K          21'h01_0000
`define UNIT_4K           21'h00_1000
`define UNIT_32K          21'h00_8000

// page program length limits, in bytes
`define PROG_LEN_MIN      9'h001
`define PROG_LEN_MAX      9'h100
`define PAGE_SUM_MAX      10'h100

// protect-extent thresholds
`define EXT_NONE          3'h0
`define EXT_ALL_64K       3'h5
`define EXT_32K_4K        3'h4
`define EXT_ALL_4K        3'h6

`endif

/* File: common/flash_protect_pkg.sv */
// flash_protect_pkg: operation codes, controller states and the span-mask
// decode shared by the protection decoder and its range checker.
// assumes flash_protect_params.svh is on the include path.
package flash_protect_pkg;
    `include "flash_protect_params.svh"

    typedef enum logic [2:0] {
        OP_PAGE_PROGRAM = 3'b000,
        OP_PAGE_ERASE   = 3'b001,
        OP_ERASE_4K     = 3'b010,
        OP_ERASE_32K    = 3'b011,
        OP_ERASE_64K    = 3'b100,
        OP_CHIP_ERASE   = 3'b101
    } flash_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_BUSY  = 2'b10
    } prot_state_e;

    // alignment mask of the address span an operation touches
    function automatic logic [`ARRAY_AW-1:0] op_span_mask(input flash_op_e op);
        logic [`ARRAY_AW-1:0] m;
        m = `MASK_PAGE;
        case (op)
            OP_PAGE_PROGRAM : m = `MASK_PAGE;
            OP_PAGE_ERASE   : m = `MASK_PAGE;
            OP_ERASE_4K     : m = `MASK_4K;
            OP_ERASE_32K    : m = `MASK_32K;
            OP_ERASE_64K    : m = `MASK_64K;
            OP_CHIP_ERASE   : m = `ARRAY_LAST;
            default         : m = `ARRAY_LAST;
        endcase
        return m;
    endfunction : op_span_mask
endpackage : flash_protect_pkg

/* File: rtl/flash_prot_range_check.sv */
// flash_prot_range_check: combinational check of one operation address span
// against the range selected by the status protection fields.
// assumes op_lo <= op_hi and both inside the 1 MB array.
`timescale 1ns/100ps
`include "flash_protect_params.svh"
module flash_prot_range_check (
    input  wire logic                          complement_protect_bit,  // invert protection
    input  wire logic                          protect_granularity_bit, // 1: 4 kB units
    input  wire logic                          range_origin_bit,        // 1: from address zero
    input  wire logic [2:0]                    protect_extent_field,    // extent code
    input  wire flash_protect_pkg::flash_op_e  op,                      // operation kind
    input  wire logic [`ARRAY_AW-1:0]          op_lo,                   // first byte touched
    input  wire logic [`ARRAY_AW-1:0]          op_hi,                   // last byte touched
    output logic                               hit                      // span meets protection
);
    import flash_protect_pkg::*;

    logic [`ARRAY_AW:0] size;
    logic [`ARRAY_AW:0] rlo;
    logic [`ARRAY_AW:0] rhi;
    logic [`ARRAY_AW:0] emask;
    logic [`ARRAY_AW:0] lo_x;
    logic [`ARRAY_AW:0] hi_x;

    always_comb
    begin
        size = '0;
        if (protect_extent_field == `EXT_NONE)
            size = '0;
        else if (!protect_granularity_bit)
            size = (protect_extent_field >= `EXT_ALL_64K) ? `ARRAY_BYTES
                 : (`UNIT_64K << (protect_extent_field - 3'h1));
        else if (protect_extent_field >= `EXT_ALL_4K)
            size = `ARRAY_BYTES;
        else if (protect_extent_field >= `EXT_32K_4K)
            size = `UNIT_32K;
        else
            size = `UNIT_4K << (protect_extent_field - 3'h1);
    end

    always_comb
    begin
        lo_x  = {1'b0, op_lo};
        hi_x  = {1'b0, op_hi};
        emask = '0;
        if (complement_protect_bit && protect_granularity_bit &&
            (op == OP_ERASE_32K || op == OP_ERASE_64K))
            emask = {1'b0, op_span_mask(op)};
        if (!range_origin_bit)
        begin
            rlo = (`ARRAY_BYTES - size) & ~emask;
            rhi = `ARRAY_BYTES - 21'h1;
        end
        else
        begin
            rlo = '0;
            rhi = (size - 21'h1) | emask;
        end
        if (!complement_protect_bit)
            hit = (size != '0) && (hi_x >= rlo) && (lo_x <= rhi);
        else
            hit = !((size != '0) && (lo_x >= rlo) && (hi_x <= rhi));
    end
endmodule : flash_prot_range_check

/* File: verification/array_engine_model.sv */
// array_engine_model: array engine and lock store beside the decoder.
// assumes one array_start pulse per granted command.
`timescale 1ns/100ps
module array_engine_model (
    input  wire logic        sys_clk,         // clock
    input  wire logic        rst_n,           // async reset, low
    input  wire logic        array_start,     // cycle request
    input  wire logic [19:0] lock_query_addr, // lock lookup
    output logic             array_done,      // cycle ended
    output logic             lock_hit         // block locked
);
    logic [3:0] cnt_reg;
    logic       slow_reg;
    ////////////////////////////////////////////////////////////
    // lock answer
    assign lock_hit = lock_query_addr[12] ^ lock_query_addr[16];
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg    <= 4'h0;
            slow_reg   <= 1'b0;
            array_done <= 1'b0;
        end
        else
        begin
            array_done <= (cnt_reg == 4'h1);
            if (array_start)
            begin
                cnt_reg  <= slow_reg ? 4'h7 : 4'h1;
                slow_reg <= ~slow_reg;
            end
            else if (cnt_reg != 4'h0)
                cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule : array_engine_model

/* File: verification/flash_block_protect_decode_bench.sv */
// flash_block_protect_decode_bench: random and corner commands, checked
// against a reference decode; assumes array_engine_model as far side.
`timescale 1ns/100ps
module flash_block_protect_decode_bench;
    import flash_protect_pkg::*;
    logic        sys_clk, rst_n, cmd_valid, lock_hit, array_done;
    logic        scheme_select_bit, complement_protect_bit;
    logic        protect_granularity_bit, range_origin_bit;
    logic [2:0]  protect_extent_field;
    logic [6:0]  f;
    flash_op_e   cmd_op, array_op;
    logic [23:0] cmd_addr;
    logic [8:0]  cmd_len;
    logic        cmd_ready, array_start, cmd_done, cmd_refused;
    logic [19:0] lock_query_addr, array_lo_addr, array_hi_addr;
    integer      seed, err_count, checks, cycles;
    assign {scheme_select_bit, complement_protect_bit, protect_granularity_bit,
            range_origin_bit, protect_extent_field} = f;
    flash_block_protect_decode uut (.sys_clk, .rst_n, .scheme_select_bit, .complement_protect_bit,
        .protect_granularity_bit, .range_origin_bit, .protect_extent_field, .cmd_valid, .cmd_op,
        .cmd_addr, .cmd_len, .lock_hit, .array_done, .cmd_ready, .lock_query_addr, .array_start,
        .array_op, .array_lo_addr, .array_hi_addr, .cmd_done, .cmd_refused);
    array_engine_model far (.sys_clk, .rst_n, .array_start, .lock_query_addr, .array_done, .lock_hit);
    ////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic summarize();
        begin
            $display("counts: %0d checks, %0d mismatches", checks, err_count);
            if (err_count == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask : summarize
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            err_count = err_count + 1;
            summarize();
        end
    end
    task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string msg);
        begin
            checks = checks + 1;
            if (seen !== exp)
            begin
                err_count = err_count + 1;
                $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
            end
        end
    endtask : check
    ////////////////////////////////////////////////////////////
    // reference decode: fields {scheme, complement, granularity, origin, extent}
    function automatic logic expect_refuse(input logic [6:0] fv, input logic [2:0] op, input logic [19:0] a,
                                           input logic [8:0] n, output logic [19:0] lo, output logic [19:0] hi);
        logic [19:0] m;
        logic [20:0] sz, rlo, rhi;
        logic [2:0]  e;
        begin
            e = fv[2:0];
            m = (op < 2) ? 20'h0_00FF : (op == 2) ? 20'h0_0FFF : (op == 3) ? 20'h0_7FFF :
                (op == 4) ? 20'h0_FFFF : 20'hF_FFFF;
            lo = a & ~m;
            hi = lo | m;
            if (op == 0 && {1'b0, a[7:0]} + n <= 9'h100)
            begin
                lo = a;
                hi = a + n - 20'h0_0001;
            end
            if (!fv[4])
                sz = (e > 4) ? 21'h10_0000 : 21'h00_8000 << e;
            else
                sz = (e > 5) ? 21'h10_0000 : (e > 3) ? 21'h00_8000 : 21'h00_0800 << e;
            rlo = fv[3] ? 21'h00_0000 : 21'h10_0000 - sz;
            rhi = rlo + sz - 21'h00_0001;
            if (fv[4] && (op == 3 || op == 4))
            begin
                rlo = rlo & ~{1'b0, m};
                rhi = rhi | {1'b0, m};
            end
            if (op > 5 || (op == 0 && (n == 0 || n > 9'h100)))
                return 1'b1;
            if (fv[6])
                return a[12] ^ a[16];
            if (!fv[5])
                return e != 0 && lo <= rhi && hi >= rlo;
            return e == 0 || lo < rlo || hi > rhi;
        end
    endfunction : expect_refuse
    task automatic run_cmd(input logic [6:0] fv, input logic [2:0] op, input logic [23:0] a, input logic [8:0] n);
        logic        xr;
        logic [19:0] lo, hi;
        int          w;
        begin
            xr = expect_refuse(fv, op, a[19:0], n, lo, hi);
            f = fv;
            cmd_op = flash_op_e'(op);
            cmd_addr = a;
            cmd_len = n;
            cmd_valid = 1;
            w = 0;
            while (cmd_ready !== 1'b1 && w < 50)
            begin
                @(posedge sys_clk);
                #1;
                w++;
            end
            @(posedge sys_clk);
            #1;
            cmd_valid = 0;
            // fields move right after acceptance
            f = 7'($random(seed));
            check(lock_query_addr, a[19:0], "query address");
            check(cmd_ready, 1'b0, "ready after accept");
            @(posedge sys_clk);
            #1;
            check(cmd_refused, xr, "refusal");
            check(array_start, !xr, "array start");
            if (!xr)
            begin
                check(array_lo_addr, lo, "span low");
                check(array_hi_addr, hi, "span high");
                check(array_op, op, "array op");
                w = 0;
                while (cmd_done !== 1'b1 && w < 50)
                begin
                    @(posedge sys_clk);
                    #1;
                    w++;
                end
            end
            check(cmd_done, 1'b1, "command done");
        end
    endtask : run_cmd
    ////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h8403_0418;
        {err_count, checks, cycles} = '0;
        {rst_n, cmd_valid, f, cmd_addr, cmd_len} = '0;
        cmd_op = OP_PAGE_PROGRAM;
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1;
        // every field setting against boundary targets
        for (int i = 0; i < 128; i++)
        begin
            run_cmd(i[6:0], 3'h3, 24'h0F_8000, 9'h001);
            run_cmd(i[6:0], 3'h4, 24'h00_0000, 9'h001);
            run_cmd(i[6:0], 3'h5, 24'h00_0000, 9'h001);
            run_cmd(i[6:0], 3'h0, 24'h0F_EFFF, 9'h002);
            run_cmd(i[6:0], 3'h1, 24'h0F_F0FF, 9'h000);
            run_cmd(i[6:0], 3'h2, 24'h00_7000, 9'h000);
        end
        run_cmd(7'h00, 3'h0, 24'h00_0100, 9'h100);
        run_cmd(7'h00, 3'h0, 24'h00_0100, 9'h101);
        run_cmd(7'h00, 3'h6, 24'h00_0100, 9'h001);
        $display("corner sweep done");
        for (int i = 0; i < 400; i++)
            run_cmd(7'($random(seed)), 3'($random(seed)), 24'($random(seed)),
                    ($random(seed) & 1) ? 9'($random(seed)) : 9'(($random(seed) & 9'h0FF) + 9'h001));
        $display("random commands done");
        summarize();
    end
endmodule : flash_block_protect_decode_bench
